// ---- design/dac_loader_pkg.sv ----
package dac_loader_pkg;

    // serial word layout
    localparam int WORD_BITS = 16;
    localparam int CODE_BITS = 10;
    localparam int CODE_MSB = 11;
    localparam int CODE_LSB = 2;
    localparam int SPEED_POS = 14;
    localparam int POWER_POS = 13;
    localparam logic [4:0] LAST_COUNT = 5'h10;

    // reset values of the converter latch
    localparam logic [9:0] CODE_RESET = 10'h000;
    localparam logic SPEED_RESET = 1'b0;
    localparam logic POWER_RESET = 1'b0;

    // fifo depth and width between shifter and converter latch
    localparam int FIFO_DEPTH = 8;
    localparam int LATCH_WIDTH = 12;

    // pin synchroniser length
    localparam int SYNC_STAGES = 3;

endpackage : dac_loader_pkg

// ---- design/dac_serial_word_loader.sv ----
// Operation
// R1: host drives chip select low first
// R2: frame sync fall starts, msb first shifting
// R3: latch after sixteen bits or frame rise
// R4: count-complete update on next rising clock
// R5: power-on reset clears all latches
// R6: chip select may be tied low
// R7: respond only while own select low
// R8: host toggles output for frame fall
// R9: byte hosts send two writes per frame
// R10: control top, code bits eleven..two
// R11: bits fifteen and twelve are ignored
// R12: bit fourteen selects fast settling mode
// R13: bit thirteen selects power down
// R14: power down disables every amplifier
// R15: unsigned code drives output level
// R16: last bit on sixteenth falling edge
// R17: host holds select through update
// R18: select high ignores all serial inputs
// R19: ignore clocks after latch until frame
`timescale 1ns/1ps
`default_nettype none

module word_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wptr;
        logic [AW:0] rptr;
    } fifo_s;

    fifo_s st_r;
    fifo_s st_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic do_wr;
    logic do_rd;

    // one extra pointer bit tells a full fifo from an empty one
    assign out_valid = st_r.wptr != st_r.rptr;
    assign in_ready = (st_r.wptr[AW] == st_r.rptr[AW]) || (st_r.wptr[AW-1:0] != st_r.rptr[AW-1:0]);
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;
    // head word shows without a read cycle, so the drain takes it at once
    assign out_data = mem[st_r.rptr[AW-1:0]];

    always_comb
    begin
        st_nxt = st_r;
        if (do_wr)
        begin
            st_nxt.wptr = st_r.wptr + 1'b1;
        end
        if (do_rd)
        begin
            st_nxt.rptr = st_r.rptr + 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (do_wr)
        begin
            mem[st_r.wptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
endmodule : word_fifo

module dac_serial_word_loader #(
    parameter int FIFO_WIDTH = dac_loader_pkg::LATCH_WIDTH,
    parameter int FIFO_DEPTH = dac_loader_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // serial pins
    input wire logic chip_select_n,
    input wire logic frame_sync_n,
    input wire logic shift_clock,
    input wire logic serial_data,
    // converter latch outputs
    output logic [9:0] dac_code,
    output logic speed_select_bit,
    output logic power_down_bit,
    output logic amp_disable,
    output logic latch_update,
    // status
    output logic word_busy,
    output logic word_overflow
);
    typedef enum logic [1:0] {IDLE, SHIFT, WAIT_RISE, DONE} phase_e;

    typedef struct packed {
        logic [2:0] cs_sync;
        logic [2:0] frame_sync;
        logic [2:0] sck_sync;
        logic [2:0] din_sync;
        logic cs_n;
        logic frame_n;
        logic sck;
        logic din;
        phase_e phase;
        logic [15:0] shreg;
        logic [4:0] count;
        logic [9:0] code;
        logic speed;
        logic power;
        logic upd;
        logic ovf;
    } loader_s;

    loader_s st_r;
    loader_s st_nxt;
    logic push;
    logic push_ready;
    logic [FIFO_WIDTH-1:0] push_word;
    logic pop_valid;
    logic [FIFO_WIDTH-1:0] pop_word;

    // a pin level counts once the second and third stages agree
    function automatic logic settle(input logic [2:0] s, input logic prev);
        settle = (s[1] == s[2]) ? s[1] : prev;
    endfunction : settle

    // keep speed, power and code; bits fifteen and twelve dropped
    // R11: bits fifteen, twelve dropped
    function automatic logic [11:0] pack_word(input logic [15:0] w);
        pack_word = {w[dac_loader_pkg::SPEED_POS], w[dac_loader_pkg::POWER_POS],
            w[dac_loader_pkg::CODE_MSB:dac_loader_pkg::CODE_LSB]};
    endfunction : pack_word

    word_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .arst_n(arst_n),
        .in_valid(push),
        .in_ready(push_ready),
        .in_data(push_word),
        .out_valid(pop_valid),
        .out_ready(1'b1),
        .out_data(pop_word)
    );

    always_comb
    begin
        logic frame_fall;
        logic frame_rise;
        logic sck_fall;
        logic sck_rise;
        logic sel;
        frame_fall = 1'b0;
        frame_rise = 1'b0;
        sck_fall = 1'b0;
        sck_rise = 1'b0;
        sel = 1'b0;
        st_nxt = st_r;
        push = 1'b0;
        // packed every cycle; push alone decides when the word counts
        push_word = pack_word(st_r.shreg);
        st_nxt.upd = 1'b0;
        st_nxt.cs_sync = {st_r.cs_sync[1:0], chip_select_n};
        st_nxt.frame_sync = {st_r.frame_sync[1:0], frame_sync_n};
        st_nxt.sck_sync = {st_r.sck_sync[1:0], shift_clock};
        st_nxt.din_sync = {st_r.din_sync[1:0], serial_data};
        st_nxt.cs_n = settle(st_r.cs_sync, st_r.cs_n);
        st_nxt.frame_n = settle(st_r.frame_sync, st_r.frame_n);
        st_nxt.sck = settle(st_r.sck_sync, st_r.sck);
        st_nxt.din = settle(st_r.din_sync, st_r.din);
        // R7: act only while selected
        // R18: select high ignores edges
        sel = !st_r.cs_n;
        frame_fall = sel && st_r.frame_n && !st_nxt.frame_n;
        frame_rise = sel && !st_r.frame_n && st_nxt.frame_n;
        sck_fall = sel && st_r.sck && !st_nxt.sck;
        sck_rise = sel && !st_r.sck && st_nxt.sck;
        case (st_r.phase)
            IDLE, DONE:
            begin
                // R2: frame fall starts word
                // R19: clocks ignored until frame fall
                // a frame rise after a finished word is ignored here
                if (frame_fall)
                begin
                    st_nxt.phase = SHIFT;
                    st_nxt.count = 5'h00;
                end
            end
            SHIFT:
            begin
                // R2: msb first on falling clock
                if (sck_fall)
                begin
                    // data uses the settled copy of this edge, so both pins carry equal delay
                    st_nxt.shreg = {st_r.shreg[14:0], st_nxt.din};
                    st_nxt.count = st_r.count + 5'h01;
                    // R16: sixteenth fall takes last bit
                    if (st_r.count + 5'h01 == dac_loader_pkg::LAST_COUNT)
                    begin
                        st_nxt.phase = WAIT_RISE;
                    end
                end
                else if (frame_rise)
                begin
                    // R3: early frame rise latches now
                    // a short word goes out as shifted, not realigned to the msb
                    push = 1'b1;
                    st_nxt.phase = DONE;
                end
            end
            WAIT_RISE:
            begin
                // R4: update on following rising clock
                // R3: frame rise also completes update
                if (sck_rise || frame_rise)
                begin
                    push = 1'b1;
                    st_nxt.phase = DONE;
                end
            end
            default:
            begin
                st_nxt.phase = IDLE;
            end
        endcase
        // the drain never stalls, so a full fifo only drops words
        if (push && !push_ready)
        begin
            st_nxt.ovf = 1'b1;
        end
        if (pop_valid)
        begin
            // R10: code from bits eleven to two
            // R12: speed bit latched
            // R13: power bit latched
            st_nxt.speed = pop_word[11];
            st_nxt.power = pop_word[10];
            st_nxt.code = pop_word[9:0];
            st_nxt.upd = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            // R5: reset clears every latch
            st_r <= '0;
            st_r.cs_sync <= 3'h7;
            st_r.frame_sync <= 3'h7;
            st_r.cs_n <= 1'b1;
            st_r.frame_n <= 1'b1;
            st_r.phase <= IDLE;
            st_r.code <= dac_loader_pkg::CODE_RESET;
            st_r.speed <= dac_loader_pkg::SPEED_RESET;
            st_r.power <= dac_loader_pkg::POWER_RESET;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // R15: unsigned code to converter
    assign dac_code = st_r.code;
    assign speed_select_bit = st_r.speed;
    assign power_down_bit = st_r.power;
    // R14: power down disables amplifiers
    assign amp_disable = st_r.power;
    assign latch_update = st_r.upd;
    // busy spans frame fall up to the hand-off into the fifo
    assign word_busy = (st_r.phase == SHIFT) || (st_r.phase == WAIT_RISE);
    assign word_overflow = st_r.ovf;
endmodule : dac_serial_word_loader

`default_nettype wire

// ---- tb/dac_loader_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module dac_loader_sva (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // serial pins
    input wire logic chip_select_n,
    input wire logic frame_sync_n,
    input wire logic shift_clock,
    input wire logic serial_data,
    // latch and status
    input wire logic [9:0] dac_code,
    input wire logic speed_select_bit,
    input wire logic power_down_bit,
    input wire logic amp_disable,
    input wire logic latch_update,
    input wire logic word_busy,
    input wire logic word_overflow
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    AST_PULSE: assert property (latch_update |=> !latch_update)
        else $error("update pulse longer than one cycle");
    AST_AMP: assert property (amp_disable == power_down_bit)
        else $error("amplifier disable differs from power down");
    AST_HOLD: assert property (!$stable({dac_code, speed_select_bit, power_down_bit}) |-> latch_update)
        else $error("latch changed without update pulse");
    AST_START: assert property ($rose(word_busy) |-> !$past(frame_sync_n, 2) && !$past(chip_select_n, 5))
        else $error("word started without frame fall under select");
    AST_NOOVF: assert property (!word_overflow)
        else $error("word overflow raised");
    AST_HAND: assert property ($fell(word_busy) |-> ##[1:3] latch_update)
        else $error("handed word not latched in time");
    AST_RESET: assert property ($rose(arst_n) |-> dac_code == 10'h000 && !speed_select_bit && !power_down_bit)
        else $error("latch not cleared by reset");
    AST_IDLE: assert property (latch_update |-> !word_busy)
        else $error("update while a word is still shifting");
endmodule : dac_loader_sva
bind dac_serial_word_loader dac_loader_sva i_sva (.clk, .arst_n, .chip_select_n, .frame_sync_n, .shift_clock,
    .serial_data, .dac_code, .speed_select_bit, .power_down_bit, .amp_disable, .latch_update, .word_busy,
    .word_overflow);
`default_nettype wire

// ---- tb/dac_serial_word_loader_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module dac_serial_word_loader_bench;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic cs_n, frame_n, sck, sdo;
    logic [9:0] dac_code;
    logic speed_select_bit, power_down_bit, amp_disable, latch_update, word_busy, word_overflow;
    int fail_count = 0;
    int n_checks = 0;
    int n_upd = 0;
    int exp_upd = 0;
    logic [15:0] exp_out = 16'h0000;
    always #12.5 clk = ~clk;
    always @(posedge clk)
        if (latch_update === 1'b1)
            n_upd++;
    host_port_model i_host (.clk, .cs_n, .frame_n, .sck, .sdo);
    dac_serial_word_loader i_dut (.clk, .arst_n, .chip_select_n(cs_n), .frame_sync_n(frame_n), .shift_clock(sck),
        .serial_data(sdo), .dac_code, .speed_select_bit, .power_down_bit, .amp_disable, .latch_update,
        .word_busy, .word_overflow);
    function automatic logic [15:0] outs();
        return {1'b0, word_overflow, word_busy, amp_disable, speed_select_bit, power_down_bit, dac_code};
    endfunction : outs
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wrap_up();
        if (fail_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    task automatic word(input logic [15:0] w, input int nb, input int extra, input logic sel_n);
        i_host.send(w, nb, extra, sel_n);
        repeat (16) @(posedge clk);
        if (!sel_n)
            exp_upd++;
        if (!sel_n && nb == 16)
            exp_out = {3'h0, w[13], w[14], w[13], w[11:2]};
    endtask : word
    initial
    begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk(outs(), 16'h0000);
        word(16'hDFFC, 16, 0, 1'b0);
        chk(outs(), exp_out);
        // extra clocks after the word must not disturb it
        word(16'h2AA8, 16, 2, 1'b0);
        chk(outs(), exp_out);
        word(16'h4004, 16, 0, 1'b1);
        chk(outs(), exp_out);
        word(16'h6000, 12, 0, 1'b0);
        chk(16'(n_upd), 16'(exp_upd));
        word(16'h4FFC, 16, 0, 1'b0);
        chk(outs(), exp_out);
        chk(16'(n_upd), 16'(exp_upd));
        // a second reset must clear the latch again
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk(outs(), 16'h0000);
        // select wired low: frame sync alone delimits the words
        i_host.tied_sel = 1'b1;
        word(16'h6554, 16, 0, 1'b0);
        chk(outs(), exp_out);
        word(16'h1004, 16, 0, 1'b0);
        chk(outs(), exp_out);
        chk(16'(n_upd), 16'(exp_upd));
        wrap_up();
    end
    initial
    begin
        #200000;
        fail_count++;
        wrap_up();
    end
endmodule : dac_serial_word_loader_bench
`default_nettype wire

// ---- tb/host_port_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
    // clock
    input wire logic clk,
    // serial pins
    output logic cs_n,
    output logic frame_n,
    output logic sck,
    output logic sdo
);
    // set by the bench when the select pin is wired low for good
    logic tied_sel = 1'b0;
    initial
    begin
        cs_n = 1'b1;
        frame_n = 1'b1;
        sck = 1'b0;
        sdo = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask : hold
    task automatic pulse();
        sck <= 1'b1;
        hold(4);
        sck <= 1'b0;
        hold(4);
    endtask : pulse
    task automatic send(input logic [15:0] w, input int nb, input int extra, input logic sel_n);
        cs_n <= sel_n;
        hold(4);
        frame_n <= 1'b0;
        hold(4);
        for (int i = 0; i < nb + extra; i++)
        begin
            // byte host pauses between its two writes
            if (i == 8)
                hold(8);
            // released data toggles so stale bits never look valid
            sdo <= (i < nb) ? w[15 - i] : ~sdo;
            pulse();
        end
        if (nb == 16)
            pulse();
        frame_n <= 1'b1;
        hold(4);
        cs_n <= ~tied_sel;
        sdo <= ~sdo;
        hold(4);
    endtask : send
endmodule : host_port_model
`default_nettype wire
